// [rrsb_intercon.sv]
// Shared bus interconnect: four masters, four slaves, round-robin grant.
// Assumes masters and slaves are synchronous to core_clk and use only ack.
//
// Behaviour
// - Four equal levels, granted in strict rotation.
// - Dropped cycle advances pointer, grants next level.
// - Levels without request are skipped.
// - Data path 32 bits, address 5 bits.
// - Slave 0 at 0x00-0x07, 1 at 0x08-0x0F.
// - Slave 2 at 0x10-0x17, 3 at 0x18-0x1F.
// - No error or retry; ack ends cycles.
// - No byte-select lines are routed.
// - Grant one edge after cycle request on an idle bus.
// - Granted master's outputs muxed onto shared bus.
// - Acks OR-combined, only granted master sees them.
// - Decoder drives strobes; read data muxed back.
`include "rrsb_regs.svh"

module rrsb_intercon #(
   parameter int DAT_W = `RRSB_DAT_W,
   parameter int ADR_W = `RRSB_ADR_W
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Master side requests
   input wire logic [`RRSB_NLEV-1:0] m_cyc,
   input wire logic [`RRSB_NLEV-1:0] m_stb,
   input wire logic [`RRSB_NLEV-1:0] m_we,
   input wire logic [`RRSB_NLEV-1:0][ADR_W-1:0] m_adr,
   input wire logic [`RRSB_NLEV-1:0][DAT_W-1:0] m_dat_wr,
   // Master side answers
   output logic [`RRSB_NLEV-1:0] m_gnt,
   output logic [`RRSB_NLEV-1:0] m_ack,
   output logic [DAT_W-1:0] m_dat_rd,
   // Shared slave bus
   output logic s_cyc,
   output logic s_we,
   output logic [ADR_W-1:0] s_adr,
   output logic [DAT_W-1:0] s_dat_wr,
   output logic [`RRSB_NLEV-1:0] s_stb,
   // Slave answers
   input wire logic [`RRSB_NLEV-1:0] s_ack,
   input wire logic [`RRSB_NLEV-1:0][DAT_W-1:0] s_dat_rd
);

   rrsb_pkg::rrsb_vec_t gnt;
   rrsb_pkg::rrsb_lvl_t gidx;
   logic gvld;

   logic s_cyc_r, s_cyc_nxt;
   logic s_we_r, s_we_nxt;
   logic [ADR_W-1:0] s_adr_r, s_adr_nxt;
   logic [DAT_W-1:0] s_dat_r, s_dat_nxt;
   rrsb_pkg::rrsb_vec_t s_stb_r, s_stb_nxt;
   rrsb_pkg::rrsb_vec_t m_ack_r, m_ack_nxt;
   logic [DAT_W-1:0] m_dat_r, m_dat_nxt;
   logic ack_any;
   logic owner_live;
   rrsb_pkg::rrsb_lvl_t rd_sel;

   // Address window to slave index, compared against the bounds
   function automatic rrsb_pkg::rrsb_lvl_t slave_of(
      input logic [ADR_W-1:0] a);
      rrsb_pkg::rrsb_lvl_t r;
      r = 2'h0;
      if (a >= `RRSB_S0_LO && a <= `RRSB_S0_HI) begin
         r = 2'h0;
      end
      if (a >= `RRSB_S1_LO && a <= `RRSB_S1_HI) begin
         r = 2'h1;
      end
      if (a >= `RRSB_S2_LO && a <= `RRSB_S2_HI) begin
         r = 2'h2;
      end
      if (a >= `RRSB_S3_LO && a <= `RRSB_S3_HI) begin
         r = 2'h3;
      end
      return r;
   endfunction

   rrsb_arbiter u_arb (
      .core_clk (core_clk),
      .rst_b (rst_b),
      .req (m_cyc),
      .gnt (gnt),
      .gnt_idx (gidx),
      .gnt_vld (gvld)
   );

   assign owner_live = gvld && m_cyc[gidx];
   // Only strobed slaves may terminate a cycle
   assign ack_any = |(s_ack & s_stb_r);
   assign rd_sel = slave_of(s_adr_r);

   always_comb begin
      s_cyc_nxt = 1'b0;
      s_we_nxt = s_we_r;
      s_adr_nxt = s_adr_r;
      s_dat_nxt = s_dat_r;
      s_stb_nxt = `RRSB_GNT_RST;
      m_ack_nxt = `RRSB_GNT_RST;
      m_dat_nxt = m_dat_r;
      if (owner_live) begin
         // Route the owner's outputs, no byte selects carried
         s_cyc_nxt = 1'b1;
         s_we_nxt = m_we[gidx];
         s_adr_nxt = m_adr[gidx];
         s_dat_nxt = m_dat_wr[gidx];
         // Strobe held off while an ack is still in flight
         if (m_stb[gidx] && !ack_any && !(|m_ack_r)) begin
            s_stb_nxt = rrsb_pkg::rrsb_vec_t'(
               4'h1 << slave_of(m_adr[gidx]));
         end
         if (ack_any) begin
            m_ack_nxt = gnt;
            m_dat_nxt = s_dat_rd[rd_sel];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         s_cyc_r <= 1'b0;
         s_we_r <= 1'b0;
         s_adr_r <= ADR_W'(`RRSB_ADR_RST);
         s_dat_r <= DAT_W'(`RRSB_DAT_RST);
         s_stb_r <= `RRSB_GNT_RST;
         m_ack_r <= `RRSB_GNT_RST;
         m_dat_r <= DAT_W'(`RRSB_DAT_RST);
      end else begin
         s_cyc_r <= s_cyc_nxt;
         s_we_r <= s_we_nxt;
         s_adr_r <= s_adr_nxt;
         s_dat_r <= s_dat_nxt;
         s_stb_r <= s_stb_nxt;
         m_ack_r <= m_ack_nxt;
         m_dat_r <= m_dat_nxt;
      end
   end

   assign s_cyc = s_cyc_r;
   assign s_we = s_we_r;
   assign s_adr = s_adr_r;
   assign s_dat_wr = s_dat_r;
   assign s_stb = s_stb_r;
   assign m_ack = m_ack_r;
   assign m_dat_rd = m_dat_r;
   // Grant comes straight from the arbiter's register
   assign m_gnt = gnt;

endmodule

// [rrsb_regs.svh]
// Constants for the round-robin shared bus interconnect.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef RRSB_REGS_SVH
`define RRSB_REGS_SVH

// Bus geometry
`define RRSB_DAT_W 32
`define RRSB_ADR_W 5
`define RRSB_NLEV 4

// Slave select field of the address
`define RRSB_SEL_HI 4
`define RRSB_SEL_LO 3

// Slave address windows, inclusive bounds
`define RRSB_S0_LO 5'h00
`define RRSB_S0_HI 5'h07
`define RRSB_S1_LO 5'h08
`define RRSB_S1_HI 5'h0F
`define RRSB_S2_LO 5'h10
`define RRSB_S2_HI 5'h17
`define RRSB_S3_LO 5'h18
`define RRSB_S3_HI 5'h1F

// Reset values
`define RRSB_GNT_RST 4'h0
`define RRSB_PTR_RST 2'h0
`define RRSB_DAT_RST 32'h0000_0000
`define RRSB_ADR_RST 5'h00

`endif

// [rrsb_pkg.sv]
// Types shared by the arbiter and the interconnect.
// Assumes rrsb_regs.svh is on the include path.
`include "rrsb_regs.svh"

package rrsb_pkg;
   typedef logic [1:0] rrsb_lvl_t;
   typedef logic [`RRSB_NLEV-1:0] rrsb_vec_t;
   typedef enum logic [0:0] {
      RRSB_IDLE,
      RRSB_OWNED
   } rrsb_arb_state_t;
endpackage

// [rrsb_arbiter.sv]
// Four-level round-robin arbiter with a registered one-hot grant.
// Assumes requests are the masters' cycle signals, synchronous to core_clk.
`include "rrsb_regs.svh"

module rrsb_arbiter (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Requests
   input wire rrsb_pkg::rrsb_vec_t req,
   // Grant
   output rrsb_pkg::rrsb_vec_t gnt,
   output rrsb_pkg::rrsb_lvl_t gnt_idx,
   output logic gnt_vld
);

   rrsb_pkg::rrsb_arb_state_t st_r, st_nxt;
   rrsb_pkg::rrsb_vec_t gnt_r, gnt_nxt;
   rrsb_pkg::rrsb_lvl_t idx_r, idx_nxt;
   rrsb_pkg::rrsb_lvl_t ptr_r, ptr_nxt;
   logic [2:0] pk;
   rrsb_pkg::rrsb_lvl_t start;

   // First requesting level at or after start; bit 2 flags a find
   function automatic logic [2:0] pick(input rrsb_pkg::rrsb_vec_t rq,
                                      input rrsb_pkg::rrsb_lvl_t st);
      logic [2:0] res;
      rrsb_pkg::rrsb_lvl_t lv;
      res = 3'h0;
      for (int i = 0; i < `RRSB_NLEV; i++) begin
         lv = rrsb_pkg::rrsb_lvl_t'(st + 2'(i));
         if (!res[2] && rq[lv]) begin
            res = {1'b1, lv};
         end
      end
      return res;
   endfunction

   always_comb begin
      st_nxt = st_r;
      gnt_nxt = gnt_r;
      idx_nxt = idx_r;
      ptr_nxt = ptr_r;
      start = ptr_r;
      pk = 3'h0;
      unique case (st_r)
         rrsb_pkg::RRSB_IDLE: begin
            pk = pick(req, ptr_r);
            if (pk[2]) begin
               st_nxt = rrsb_pkg::RRSB_OWNED;
               idx_nxt = pk[1:0];
               gnt_nxt = rrsb_pkg::rrsb_vec_t'(4'h1 << pk[1:0]);
            end
         end
         rrsb_pkg::RRSB_OWNED: begin
            if (!req[idx_r]) begin
               // Owner let go: turn to the next level
               start = rrsb_pkg::rrsb_lvl_t'(idx_r + 2'h1);
               ptr_nxt = start;
               pk = pick(req, start);
               if (pk[2]) begin
                  idx_nxt = pk[1:0];
                  gnt_nxt = rrsb_pkg::rrsb_vec_t'(4'h1 << pk[1:0]);
               end else begin
                  st_nxt = rrsb_pkg::RRSB_IDLE;
                  gnt_nxt = `RRSB_GNT_RST;
               end
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         st_r <= rrsb_pkg::RRSB_IDLE;
         gnt_r <= `RRSB_GNT_RST;
         idx_r <= `RRSB_PTR_RST;
         ptr_r <= `RRSB_PTR_RST;
      end else begin
         st_r <= st_nxt;
         gnt_r <= gnt_nxt;
         idx_r <= idx_nxt;
         ptr_r <= ptr_nxt;
      end
   end

   assign gnt = gnt_r;
   assign gnt_idx = idx_r;
   assign gnt_vld = (st_r == rrsb_pkg::RRSB_OWNED);

endmodule

// [rrsb_monitor.sv]
// Assertion checker for the shared bus interconnect.
// Assumes one clock and a synchronous active-low reset.
module rrsb_monitor #(
   parameter int ADR_W = 5
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Master side
   input wire logic [3:0] m_cyc,
   input wire logic [3:0] m_we,
   input wire logic [3:0][ADR_W-1:0] m_adr,
   input wire logic [3:0] m_gnt,
   input wire logic [3:0] m_ack,
   // Slave side
   input wire logic s_cyc,
   input wire logic s_we,
   input wire logic [ADR_W-1:0] s_adr,
   input wire logic [3:0] s_stb,
   input wire logic [3:0] s_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] nx;
   logic [ADR_W-1:0] sa;
   logic sw;
   // Next requester after the owner, and the owner's bus outputs
   always_comb begin
      nx = 4'h0;
      sa = '0;
      sw = 1'b0;
      for (int k = 3; k > 0; k--)
         for (int i = 0; i < 4; i++)
            if (m_gnt[i] && m_cyc[(i + k) % 4])
               nx = 4'h1 << ((i + k) % 4);
      for (int i = 0; i < 4; i++)
         if (m_gnt[i]) begin
            sa = m_adr[i];
            sw = m_we[i];
         end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence hit; (s_stb & s_ack) != 4'h0; endsequence
   sequence stb_up; s_stb != 4'h0 && $past(s_stb) == 4'h0; endsequence
   chk_gnt_onehot: assert property ($onehot0(m_gnt))
      else $error("grant not one-hot");
   chk_gnt_soon: assert property (m_gnt == 4'h0 && m_cyc != 4'h0
      |=> (m_gnt & $past(m_cyc)) != 4'h0) else $error("no grant");
   chk_gnt_keep: assert property ((m_gnt & m_cyc) != 4'h0
      |=> $stable(m_gnt)) else $error("grant moved");
   chk_gnt_next: assert property (m_gnt != 4'h0
      && (m_gnt & m_cyc) == 4'h0 |=> m_gnt == $past(nx))
      else $error("wrong next grant");
   chk_ack_route: assert property (hit |=> m_ack == $past(m_gnt))
      else $error("ack misrouted");
   chk_ack_cause: assert property (m_ack != 4'h0
      |-> $past(s_stb & s_ack) != 4'h0) else $error("stray ack");
   chk_dec_low: assert property (s_stb != 4'h0 && s_adr <= 5'h0F
      |-> s_stb == (s_adr <= 5'h07 ? 4'h1 : 4'h2)) else $error("decode");
   chk_dec_high: assert property (s_stb != 4'h0 && s_adr >= 5'h10
      |-> s_stb == (s_adr <= 5'h17 ? 4'h4 : 4'h8)) else $error("decode");
   chk_bus_mux: assert property (stb_up |-> s_cyc
      && s_adr == $past(sa) && s_we == $past(sw)) else $error("bus mux");
   chk_rst_idle: assert property (disable iff (1'b0) !rst_b
      |=> m_gnt == 4'h0 && m_ack == 4'h0 && s_stb == 4'h0)
      else $error("not idle after reset");
endmodule
bind rrsb_intercon rrsb_monitor #(.ADR_W(ADR_W)) u_rrsb_monitor (
   .core_clk (core_clk),
   .rst_b (rst_b),
   .m_cyc (m_cyc),
   .m_we (m_we),
   .m_adr (m_adr),
   .m_gnt (m_gnt),
   .m_ack (m_ack),
   .s_cyc (s_cyc),
   .s_we (s_we),
   .s_adr (s_adr),
   .s_stb (s_stb),
   .s_ack (s_ack)
);

// [rrsb_slaves.sv]
// Four model slaves on the shared bus; read data is made from the slave index and address.
// Assumes slow asks for a wait state on every other cycle.
module rrsb_slaves (
   // Clock and pace
   input wire logic core_clk,
   input wire logic slow,
   // Shared bus
   input wire logic [4:0] s_adr,
   input wire logic [3:0] s_stb,
   // Answers
   output logic [3:0] s_ack,
   output logic [3:0][31:0] s_dat_rd
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wt_r = 1'b0;
   logic [31:0] junk_r = 32'h0000_0000;
   always_ff @(posedge core_clk) begin
      wt_r <= !wt_r;
      junk_r <= junk_r + 32'h1357_9BDF;
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         s_ack[i] = s_stb[i] && (!slow || wt_r);
         s_dat_rd[i] = s_stb[i] ? {22'h2A_5000, 2'(i), 3'h0, s_adr} : junk_r;
      end
   end
endmodule

// [rrsb_intercon_tb.sv]
// Self-checking bench for the shared bus interconnect.
// Assumes the slave model answers on the shared bus.
module rrsb_intercon_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic slow = 1'b0;
   logic [3:0] m_cyc = '0, m_stb = '0, m_we = '0;
   logic [3:0][4:0] m_adr = '0;
   logic [3:0][31:0] m_dat_wr = '0;
   logic [3:0] m_gnt, m_ack, s_stb, s_ack;
   logic [31:0] m_dat_rd, s_dat_wr;
   logic [3:0][31:0] s_dat_rd;
   logic s_cyc, s_we;
   logic [4:0] s_adr;
   logic [3:0] prev_g = '0;
   logic [64:0] exp_q[4][$];
   int exp_g[$];
   int mismatches = 0;
   int tests_run = 0;
   rrsb_intercon u_rrsb_intercon (
      .core_clk (core_clk),
      .rst_b (rst_b),
      .m_cyc (m_cyc),
      .m_stb (m_stb),
      .m_we (m_we),
      .m_adr (m_adr),
      .m_dat_wr (m_dat_wr),
      .m_gnt (m_gnt),
      .m_ack (m_ack),
      .m_dat_rd (m_dat_rd),
      .s_cyc (s_cyc),
      .s_we (s_we),
      .s_adr (s_adr),
      .s_dat_wr (s_dat_wr),
      .s_stb (s_stb),
      .s_ack (s_ack),
      .s_dat_rd (s_dat_rd)
   );
   rrsb_slaves u_rrsb_slaves (
      .core_clk (core_clk),
      .slow (slow),
      .s_adr (s_adr),
      .s_stb (s_stb),
      .s_ack (s_ack),
      .s_dat_rd (s_dat_rd)
   );
   initial forever #2.5 core_clk = ~core_clk;
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      if (mismatches == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // One master: cycle of n phases, next phase shown in the ack cycle
   task automatic mst(input int m, input int n);
      logic [4:0] a;
      logic [1:0] sl;
      int t;
      @(negedge core_clk);
      m_cyc[m] = 1'b1;
      for (int p = 0; p < n; p++) begin
         a = 5'($urandom);
         sl = a <= 5'h07 ? 2'h0 : a <= 5'h0F ? 2'h1 : a <= 5'h17 ? 2'h2 : 2'h3;
         m_adr[m] = a;
         m_we[m] = 1'($urandom);
         m_dat_wr[m] = $urandom;
         m_stb[m] = 1'b1;
         exp_q[m].push_back({!m_we[m], m_dat_wr[m], 22'h2A_5000, sl, 3'h0,
                             a});
         t = 0;
         do begin
            @(negedge core_clk);
            t++;
         end while (m_ack[m] !== 1'b1 && t < 300);
         if (t >= 300)
            mismatches++;
      end
      m_stb[m] = 1'b0;
      m_cyc[m] = 1'b0;
   endtask
   always @(negedge core_clk) begin
      logic [64:0] e;
      for (int m = 0; m < 4; m++)
         if (m_ack[m] === 1'b1) begin
            e = exp_q[m].pop_front();
            chk("ack", m_ack, 4'h1 << m);
            chk("ack owner", m_gnt, 4'h1 << m);
            chk("cyc", s_cyc, 32'h0000_0001);
            chk("adr", s_adr, e[4:0]);
            chk("we", s_we, !e[64]);
            if (e[64])
               chk("rdata", m_dat_rd, e[31:0]);
            else
               chk("wdata", s_dat_wr, e[63:32]);
         end
      if (m_gnt !== prev_g && m_gnt !== 4'h0)
         chk("gnt", m_gnt, 4'h1 << exp_g.pop_front());
      prev_g = m_gnt;
   end
   initial begin
      void'($urandom(32'h91a9));
      exp_g = '{0, 1, 2, 3, 1, 3, 1, 0, 3};
      repeat (12) @(negedge core_clk);
      rst_b = 1'b1;
      fork
         mst(0, 2);
         mst(1, 2);
         mst(2, 3);
         mst(3, 1);
      join
      slow = 1'b1;
      fork
         mst(1, 1);
         mst(3, 2);
      join
      mst(1, 1);
      rst_b = 1'b0;
      repeat (2) @(negedge core_clk);
      rst_b = 1'b1;
      chk("idle after reset", {s_cyc, m_gnt, m_ack, s_stb}, 32'h0000_0000);
      fork
         mst(0, 1);
         mst(3, 1);
      join
      repeat (5) @(negedge core_clk);
      chk("grants left", exp_g.size(), 0);
      tally_and_finish;
   end
   initial begin
      #20000;
      mismatches++;
      tally_and_finish;
   end
endmodule
